// ### rtl/snf_defines.svh
// Constants of the serial flash command and feature block
// Functional notes
// - Load-random and get feature repeat without abort
// - ECC disabled means no bit-flip reporting
// - Erase whole block, page bits ignored
// - Both reset opcodes abort and go busy
// - Write enable sets the write latch
// - Write disable clears latch; writes then ignored
// - Feature bits survive reset commands
// - Set feature never touches write latch
// - Reserved feature bits read zero
// - ECC bits valid only with ECC enabled
// - Power-on restores all feature defaults
// - Lock guard with pin low blocks lock writes
// - Three lock bits select locked upper region
// - Protect execute only while protect allowed
// - ID read select switches read mode
// - Bad block guard reads one, read only
// - Fast read defaults on, zero disables
// - Busy flag high while busy, low ready
// - Erase fail set on failed or locked erase
// - Get feature repeats byte, live status
`ifndef SNF_DEFINES_SVH
`define SNF_DEFINES_SVH
// Opcodes
`define SNF_OP_WREN 8'h06
`define SNF_OP_WRDI 8'h04
`define SNF_OP_RST1 8'hFF
`define SNF_OP_RST2 8'hFE
`define SNF_OP_ERASE 8'hD8
`define SNF_OP_PROG 8'h10
`define SNF_OP_PROT 8'h2A
`define SNF_OP_LOADR 8'h84
`define SNF_OP_SETF 8'h1F
`define SNF_OP_GETF 8'h0F
// Feature addresses
`define SNF_FA_LOCK 8'hA0
`define SNF_FA_FUNC 8'hB0
`define SNF_FA_STAT 8'hC0
`define SNF_FA_THR 8'h10
`define SNF_FA_BFS 8'h20
`define SNF_FA_MBF 8'h30
`define SNF_FA_BFRL 8'h40
`define SNF_FA_BFRH 8'h50
// Field positions
`define SNF_LK_BLK 7
`define SNF_FN_PRT 7
`define SNF_FN_IDR 6
`define SNF_FN_ECC 4
`define SNF_FN_BBI 2
`define SNF_FN_HSE 1
// Reset values and writable masks
`define SNF_LOCK_RST 8'h38
`define SNF_FUNC_RST 8'h16
`define SNF_THR_RST 8'h00
`define SNF_LOCK_WMASK 8'hB8
`define SNF_FUNC_WMASK 8'hD2
`define SNF_THR_WMASK 8'hF0
// Array geometry
`define SNF_NUM_BLOCKS 11'h400
// Timing
`define SNF_CLK_NS 5
`define SNF_T_ERASE_NS 20000
`define SNF_T_PROG_NS 3000
`define SNF_T_RST_NS 500
`endif

// ### rtl/snf_pkg.sv
// Types of the serial flash command and feature block
`default_nettype none
package snf_pkg;
   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_WREN = 3'b001,
      CMD_WRDI = 3'b010,
      CMD_RESET = 3'b011,
      CMD_ERASE = 3'b100,
      CMD_PROG = 3'b101,
      CMD_PROT = 3'b110,
      CMD_SETF = 3'b111
   } snf_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG = 2'b10,
      ST_RESET = 2'b11
   } snf_state_t;
   typedef struct packed {
      snf_cmd_t cmd;
      logic [15:0] row;
      logic [7:0] fa;
      logic [7:0] data;
   } snf_msg_t;
   typedef struct packed {
      logic [7:0] a0;
      logic [7:0] b0;
      logic [7:0] c0;
      logic [7:0] f10;
      logic [7:0] f20;
      logic [7:0] f30;
      logic [7:0] f40;
      logic [7:0] f50;
   } snf_pub_t;
endpackage
`default_nettype wire

// ### rtl/snf_ctrl.sv
// Serial flash command interpreter with feature table and busy engine
`timescale 1ns/1ps
`include "snf_defines.svh"
`default_nettype none
module snf_ctrl #(
   parameter int ERASE_CYC = `SNF_T_ERASE_NS / `SNF_CLK_NS,
   parameter int PROG_CYC = `SNF_T_PROG_NS / `SNF_CLK_NS,
   parameter int RST_CYC = `SNF_T_RST_NS / `SNF_CLK_NS
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SI,
   output var logic SO,
   output var logic SO_OE,
   input wire logic WP_N,
   input wire logic [1:0] ECC_STAT,
   input wire logic [3:0] BF_CNT,
   output logic BUSY,
   output logic ECC_ON,
   output logic ID_MODE,
   output logic FAST_READ,
   output logic PROT_ALLOW,
   output logic [2:0] LOCK_RANGE
);

   // ==========================================================
   // Link side, clocked by SCK
   // ==========================================================
   // Frame reset: link state clears whenever chip select is high
   logic lrst_n;
   assign lrst_n = ARST_N & ~CS_N;

   logic [2:0] bc_q;
   logic [2:0] bi_q;
   logic [6:0] sh_q;
   logic [7:0] op_q;
   logic [7:0] fa_q;
   logic [7:0] rh_q;
   logic [7:0] byte_w;
   logic done_w;
   logic op_end, b1_end, b2_end, b3_end;

   assign byte_w = {sh_q, SI};
   assign done_w = (bc_q == 3'd7);
   assign op_end = done_w && (bi_q == 3'd0);
   assign b1_end = done_w && (bi_q == 3'd1);
   assign b2_end = done_w && (bi_q == 3'd2);
   assign b3_end = done_w && (bi_q == 3'd3);

   // Bit and byte counters, byte index saturates past the address
   always_ff @(posedge SCK or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         bc_q <= 3'd0;
         bi_q <= 3'd0;
         sh_q <= 7'h00;
      end
      else
      begin
         bc_q <= bc_q + 3'd1;
         sh_q <= byte_w[6:0];
         if (done_w && bi_q != 3'd4)
            bi_q <= bi_q + 3'd1;
      end
   end

   // Opcode and address bytes
   always_ff @(posedge SCK or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         op_q <= 8'h00;
         fa_q <= 8'h00;
         rh_q <= 8'h00;
      end
      else
      begin
         if (op_end)
            op_q <= byte_w;
         if (b1_end)
            fa_q <= byte_w;
         if (b2_end)
            rh_q <= byte_w;
      end
   end

   // Command decode; load-random is taken and simply not forwarded
   logic is_rst_op, is_row_op;
   snf_pkg::snf_cmd_t row_cmd;
   snf_pkg::snf_cmd_t cmd_w;
   assign is_rst_op = (byte_w == `SNF_OP_RST1) || (byte_w == `SNF_OP_RST2);
   assign row_cmd = (op_q == `SNF_OP_ERASE) ? snf_pkg::CMD_ERASE :
                    (op_q == `SNF_OP_PROG) ? snf_pkg::CMD_PROG :
                    (op_q == `SNF_OP_PROT) ? snf_pkg::CMD_PROT :
                    snf_pkg::CMD_NONE;
   assign is_row_op = b3_end && (row_cmd != snf_pkg::CMD_NONE);
   assign cmd_w = (op_end && byte_w == `SNF_OP_WREN) ? snf_pkg::CMD_WREN :
                  (op_end && byte_w == `SNF_OP_WRDI) ? snf_pkg::CMD_WRDI :
                  (op_end && is_rst_op) ? snf_pkg::CMD_RESET :
                  (b2_end && op_q == `SNF_OP_SETF) ? snf_pkg::CMD_SETF :
                  is_row_op ? row_cmd :
                  snf_pkg::CMD_NONE;

   // Message holder and toggle; not cleared by chip select
   // Holder stays put for a full byte, far longer than the sync delay
   snf_pkg::snf_msg_t msg_q;
   logic tog_q;
   always_ff @(posedge SCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         msg_q <= '0;
         tog_q <= 1'b0;
      end
      else if (cmd_w != snf_pkg::CMD_NONE)
      begin
         msg_q <= '{cmd: cmd_w, row: {rh_q, byte_w}, fa: fa_q, data: byte_w};
         tog_q <= ~tog_q;
      end
   end

   // Published feature bytes, synchronised bit by bit
   // Config bytes only move between frames; status bits are independent
   snf_pkg::snf_pub_t pub_q;
   snf_pkg::snf_pub_t ps1_q;
   snf_pkg::snf_pub_t ps2_q;
   always_ff @(posedge SCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ps1_q <= '0;
         ps2_q <= '0;
      end
      else
      begin
         ps1_q <= pub_q;
         ps2_q <= ps1_q;
      end
   end

   // Read byte select; undefined addresses answer zero
   logic [7:0] rd_byte;
   logic get_act;
   assign rd_byte = (fa_q == `SNF_FA_LOCK) ? ps2_q.a0 :
                    (fa_q == `SNF_FA_FUNC) ? ps2_q.b0 :
                    (fa_q == `SNF_FA_STAT) ? ps2_q.c0 :
                    (fa_q == `SNF_FA_THR) ? ps2_q.f10 :
                    (fa_q == `SNF_FA_BFS) ? ps2_q.f20 :
                    (fa_q == `SNF_FA_MBF) ? ps2_q.f30 :
                    (fa_q == `SNF_FA_BFRL) ? ps2_q.f40 :
                    (fa_q == `SNF_FA_BFRH) ? ps2_q.f50 :
                    8'h00;
   assign get_act = (op_q == `SNF_OP_GETF) && (bi_q >= 3'd2);

   // Output shifts on the falling edge, same byte until CS rises
   always_ff @(negedge SCK or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         SO <= 1'b0;
         SO_OE <= 1'b0;
      end
      else
      begin
         SO <= get_act & rd_byte[3'd7 - bc_q];
         SO_OE <= get_act;
      end
   end

   // ==========================================================
   // Core side, clocked by CLK
   // ==========================================================
   // Toggle and write-protect pin synchronisers
   logic t1_q, t2_q, t3_q;
   logic wp1_q, wp2_q;
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         t1_q <= 1'b0;
         t2_q <= 1'b0;
         t3_q <= 1'b0;
         wp1_q <= 1'b1;
         wp2_q <= 1'b1;
      end
      else
      begin
         t1_q <= tog_q;
         t2_q <= t1_q;
         t3_q <= t2_q;
         wp1_q <= WP_N;
         wp2_q <= wp1_q;
      end
   end

   logic ev;
   assign ev = t2_q ^ t3_q;

   // Feature and status state
   snf_pkg::snf_state_t st_q;
   logic [11:0] cnt_q;
   logic [7:0] lock_q;
   logic [7:0] func_q;
   logic [7:0] thr_q;
   logic wel_q;
   logic program_fail_flag_q;
   logic erase_fail_flag_q;

   // Command qualification; commands other than reset are dropped while busy
   logic idle;
   logic ev_wren;
   logic ev_wrdi;
   logic ev_rst;
   logic ev_ers;
   logic ev_prg;
   logic ev_prt;
   logic ev_setf;
   assign idle = (st_q == snf_pkg::ST_IDLE);
   assign ev_wren = ev && idle && msg_q.cmd == snf_pkg::CMD_WREN;
   assign ev_wrdi = ev && idle && msg_q.cmd == snf_pkg::CMD_WRDI;
   assign ev_rst = ev && msg_q.cmd == snf_pkg::CMD_RESET;
   assign ev_ers = ev && idle && wel_q && msg_q.cmd == snf_pkg::CMD_ERASE;
   assign ev_prg = ev && idle && wel_q && msg_q.cmd == snf_pkg::CMD_PROG;
   assign ev_prt = ev && idle && wel_q && func_q[`SNF_FN_PRT] &&
                   msg_q.cmd == snf_pkg::CMD_PROT;
   assign ev_setf = ev && idle && msg_q.cmd == snf_pkg::CMD_SETF;

   // Lock region check on the block part of the row only
   logic [9:0] blk_w;
   logic [2:0] lr_w;
   logic [10:0] span_w;
   logic [10:0] lo_w;
   logic lk_w;
   assign blk_w = msg_q.row[15:6];
   assign lr_w = lock_q[5:3];
   assign span_w = `SNF_NUM_BLOCKS >> (3'd7 - lr_w);
   assign lo_w = `SNF_NUM_BLOCKS - span_w;
   assign lk_w = (lr_w != 3'b000) && ({1'b0, blk_w} >= lo_w);

   // Busy sequencer; reset aborts and holds busy while discharging
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st_q <= snf_pkg::ST_IDLE;
         cnt_q <= 12'h000;
      end
      else if (ev_rst)
      begin
         st_q <= snf_pkg::ST_RESET;
         cnt_q <= 12'(RST_CYC - 1);
      end
      else if (ev_ers)
      begin
         st_q <= snf_pkg::ST_ERASE;
         cnt_q <= 12'(ERASE_CYC - 1);
      end
      else if (ev_prg || ev_prt)
      begin
         st_q <= snf_pkg::ST_PROG;
         cnt_q <= 12'(PROG_CYC - 1);
      end
      else if (!idle)
      begin
         if (cnt_q == 12'h000)
            st_q <= snf_pkg::ST_IDLE;
         else
            cnt_q <= cnt_q - 12'h001;
      end
   end

   // Pass or fail of the last erase and program
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         erase_fail_flag_q <= 1'b0;
         program_fail_flag_q <= 1'b0;
      end
      else
      begin
         if (ev_ers)
            erase_fail_flag_q <= lk_w;
         if (ev_prg || ev_prt)
            program_fail_flag_q <= lk_w;
      end
   end

   // Write latch: only the two latch commands move it
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         wel_q <= 1'b0;
      else if (ev_wren)
         wel_q <= 1'b1;
      else if (ev_wrdi)
         wel_q <= 1'b0;
   end

   // Feature writes; only power-on reset restores defaults
   logic lk_guard;
   assign lk_guard = lock_q[`SNF_LK_BLK] && !wp2_q;
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         lock_q <= `SNF_LOCK_RST;
         func_q <= `SNF_FUNC_RST;
         thr_q <= `SNF_THR_RST;
      end
      else if (ev_setf)
      begin
         if (msg_q.fa == `SNF_FA_LOCK && !lk_guard)
            lock_q <= msg_q.data & `SNF_LOCK_WMASK;
         if (msg_q.fa == `SNF_FA_FUNC)
            func_q <= (msg_q.data & `SNF_FUNC_WMASK) | 8'h04;
         if (msg_q.fa == `SNF_FA_THR)
            thr_q <= msg_q.data & `SNF_THR_WMASK;
      end
   end

   // Published view; ECC fields zero while ECC is off
   logic ecc_on;
   snf_pkg::snf_pub_t pub_d;
   assign ecc_on = func_q[`SNF_FN_ECC];
   assign pub_d.a0 = lock_q;
   assign pub_d.b0 = func_q;
   assign pub_d.c0 = {2'b00, ECC_STAT & {2{ecc_on}}, program_fail_flag_q, erase_fail_flag_q,
                      wel_q, !idle};
   assign pub_d.f10 = thr_q;
   assign pub_d.f20 = {4'h0, BF_CNT & {4{ecc_on}}};
   assign pub_d.f30 = 8'h00;
   assign pub_d.f40 = 8'h00;
   assign pub_d.f50 = 8'h00;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         pub_q <= '{a0: `SNF_LOCK_RST, b0: `SNF_FUNC_RST, f10: `SNF_THR_RST, default: 8'h00};
      else
         pub_q <= pub_d;
   end

   // Busy from the sequencer state, mode outputs straight from the feature flops
   assign BUSY = !idle;
   assign ECC_ON = ecc_on;
   assign ID_MODE = func_q[`SNF_FN_IDR];
   assign FAST_READ = func_q[`SNF_FN_HSE];
   assign PROT_ALLOW = func_q[`SNF_FN_PRT];
   assign LOCK_RANGE = lock_q[5:3];

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   a_wel_set: assert property (ev_wren |=> wel_q)
      else $error("write latch not set");
   a_wel_setf: assert property (ev_setf |=> wel_q == $past(wel_q))
      else $error("set feature moved write latch");
   a_wel_gate: assert property (ev && idle && !wel_q &&
      msg_q.cmd == snf_pkg::CMD_ERASE |=> idle)
      else $error("erase taken without latch");
   a_erase_busy: assert property (ev_ers |=> (!idle)[*8])
      else $error("erase busy too short");
   a_reset_abort: assert property (ev_rst |=> st_q == snf_pkg::ST_RESET)
      else $error("reset did not abort");
   a_feat_keep: assert property (ev_rst |=>
      $stable(lock_q) && $stable(func_q) && $stable(thr_q))
      else $error("reset changed features");
   a_lock_guard: assert property (ev_setf && msg_q.fa == `SNF_FA_LOCK &&
      lk_guard |=> $stable(lock_q))
      else $error("guarded lock written");
   a_ecc_off: assert property (!ecc_on |=> pub_q.c0[5:4] == 2'b00 &&
      pub_q.f20 == 8'h00)
      else $error("ecc fields while off");
   a_rsvd_zero: assert property (pub_q.a0[6] == 1'b0 && pub_q.a0[2:0] == 3'b000 &&
      pub_q.b0[5] == 1'b0 && pub_q.b0[3] == 1'b0 && pub_q.b0[0] == 1'b0 &&
      pub_q.c0[7:6] == 2'b00)
      else $error("reserved bit set");
   a_bbi_one: assert property (func_q[`SNF_FN_BBI])
      else $error("bad block guard cleared");
   a_ers_fail: assert property (ev_ers |=> erase_fail_flag_q == $past(lk_w))
      else $error("erase fail wrong");
   a_prot_gate: assert property (ev && idle && !func_q[`SNF_FN_PRT] &&
      msg_q.cmd == snf_pkg::CMD_PROT |=> idle)
      else $error("protect taken while disallowed");
   a_busy_pub: assert property (ev_ers |=> ##1 pub_q.c0[0])
      else $error("busy not published");

endmodule
`default_nettype wire

// ### tb/snf_host_model.sv
// Host serial link model that frames flash commands
`timescale 1ns/1ps
`default_nettype none
module snf_host_model (
   output logic SCK,
   output logic CS_N,
   output logic SI,
   input wire logic SO
);
   // ==========================================
   // Link idle state
   // Clock parked low between frames, select released
   initial
   begin
      SCK = 1'b0;
      CS_N = 1'b1;
      SI = 1'b0;
   end

   // ==========================================
   // Byte and frame tasks
   // MSB first; SO is taken at the rise, half a bit after it moved
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         SI = tx[i];
         #3 SCK = 1'b1;
         rx[i] = SO;
         #3 SCK = 1'b0;
      end
   endtask

   // Opcode bytes, then rd answer bytes; first and last answer come back
   task automatic frame(input int n, input logic [31:0] tx, input int rd,
      output logic [7:0] r0, output logic [7:0] r1);
      logic [7:0] d;
      CS_N = 1'b0;
      #4;
      for (int k = 0; k < n; k++)
         xbyte(tx[31-8*k -: 8], d);
      for (int k = 0; k < rd; k++)
      begin
         xbyte(8'h00, d);
         if (k == 0)
            r0 = d;
         r1 = d;
      end
      #3 CS_N = 1'b1;
      SI = ~SI; // Released line must not show a stale bit
      #12;
   endtask
endmodule
`default_nettype wire

// ### tb/test_serial_nand_feature_erase_ctrl.sv
// Self-checking bench for the serial flash command and feature block
`timescale 1ns/1ps
`default_nettype none
module test_serial_nand_feature_erase_ctrl;
   logic CLK, ARST_N, WP_N, SCK, CS_N, SI, SO, SO_OE, BUSY;
   logic [1:0] ECC_STAT;
   logic [3:0] BF_CNT;
   logic ECC_ON, ID_MODE, FAST_READ, PROT_ALLOW;
   logic [2:0] LOCK_RANGE;
   logic [7:0] r0, r1;
   int fail_count = 0;
   int n_checks = 0;
   wire logic [7:0] pins = {1'b0, ECC_ON, ID_MODE, FAST_READ, PROT_ALLOW, LOCK_RANGE};

   // ==========================================
   // Design, host and clock
   // Short busy counts keep the run small; erase outlasts a reset frame
   snf_ctrl #(.ERASE_CYC(60), .PROG_CYC(10), .RST_CYC(5)) u_dut (
      .CLK(CLK), .ARST_N(ARST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
      .SO_OE(SO_OE), .WP_N(WP_N), .ECC_STAT(ECC_STAT), .BF_CNT(BF_CNT), .BUSY(BUSY),
      .ECC_ON(ECC_ON), .ID_MODE(ID_MODE), .FAST_READ(FAST_READ),
      .PROT_ALLOW(PROT_ALLOW), .LOCK_RANGE(LOCK_RANGE));
   snf_host_model u_host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO));
   initial
   begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Command frame, then room for the core to act on it
   task automatic cmd(input int n, input logic [31:0] tx);
      u_host.frame(n, tx, 0, r0, r1);
      repeat (5) @(negedge CLK);
   endtask
   task automatic setf(input logic [7:0] a, input logic [7:0] d);
      cmd(3, {8'h1F, a, d, 8'h00});
   endtask
   // Two answer bytes, both must hold the same value
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_host.frame(2, {8'h0F, a, 16'h0000}, 2, r0, r1);
      chk(r0, e);
      chk(r1, e);
   endtask
   task automatic wait_idle(input int lim);
      int k;
      k = 0;
      while (BUSY !== 1'b0 && k < lim)
      begin
         @(negedge CLK);
         k++;
      end
      chk({7'h00, BUSY}, 8'h00);
   endtask
   task automatic erase(input logic [9:0] blk, input logic [5:0] pg, input logic fail);
      cmd(1, 32'h0600_0000);
      cmd(4, {8'hD8, 8'h00, blk, pg});
      chk({7'h00, BUSY}, 8'h01);
      wait_idle(80);
      rd(8'hC0, {5'h00, fail, 2'h2});
   endtask

   // ==========================================
   // Scenarios
   task automatic t_defaults();
      logic [7:0] a[8] = '{8'hA0, 8'hB0, 8'hC0, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50};
      logic [7:0] e[8] = '{8'h38, 8'h16, 8'h30, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00};
      chk(pins, 8'h57);
      for (int i = 0; i < 8; i++)
         rd(a[i], e[i]);
      rd(8'h50, 8'h00);
      setf(8'hB0, 8'h00);
      rd(8'hB0, 8'h04);
      rd(8'hC0, 8'h00);
      rd(8'h20, 8'h00);
      chk(pins, 8'h07);
      setf(8'hB0, 8'hFF);
      rd(8'hB0, 8'hD6);
      chk(pins, 8'h7F);
      setf(8'h10, 8'hFF);
      rd(8'h10, 8'hF0);
      setf(8'hB0, 8'h16);
      ECC_STAT = 2'h0;
      BF_CNT = 4'h0;
   endtask
   task automatic t_latch();
      cmd(1, 32'h0600_0000);
      rd(8'hC0, 8'h02);
      setf(8'hC0, 8'h00);
      rd(8'hC0, 8'h02);
      cmd(1, 32'h0400_0000);
      rd(8'hC0, 8'h00);
      setf(8'hC0, 8'hFF);
      rd(8'hC0, 8'h00);
      cmd(4, 32'hD800_0000);
      chk({7'h00, BUSY}, 8'h00);
   endtask
   task automatic t_guard();
      setf(8'hA0, 8'h80);
      WP_N = 1'b0;
      setf(8'hA0, 8'h38);
      rd(8'hA0, 8'h80);
      WP_N = 1'b1;
      repeat (4) @(negedge CLK);
      setf(8'hA0, 8'h28);
      rd(8'hA0, 8'h28);
      chk(pins, 8'h55);
   endtask
   // Last free block passes, first locked block fails, for each range code that has one (code 0 has no locked block, code 7 no free block)
   task automatic t_range();
      int lo;
      for (int n = 0; n < 8; n++)
      begin
         setf(8'hA0, {2'h0, n[2:0], 3'h0});
         chk(pins, {5'h0A, n[2:0]});
         lo = (n == 0) ? 1024 : (n == 7) ? 0 : 1024 - (1024 >> (7 - n));
         if (lo > 0)
            erase(10'(lo - 1), 6'h3F, 1'b0);
         if (lo < 1024)
            erase(10'(lo), 6'h00, 1'b1);
      end
   endtask
   task automatic t_reset();
      logic [7:0] ops[2] = '{8'hFF, 8'hFE};
      setf(8'hA0, 8'h00);
      setf(8'hB0, 8'h14);
      erase(10'h004, 6'h00, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         cmd(1, 32'h0600_0000);
         cmd(4, 32'hD800_0100);
         cmd(1, {ops[i], 24'h00_0000});
         wait_idle(20);
         rd(8'hC0, 8'h02);
         rd(8'hA0, 8'h00);
         rd(8'hB0, 8'h14);
      end
   endtask
   task automatic t_prot();
      cmd(1, 32'h0600_0000);
      cmd(4, 32'h2A00_0200);
      chk({7'h00, BUSY}, 8'h00);
      setf(8'hB0, 8'h96);
      chk(pins, 8'h58);
      cmd(4, 32'h2A00_0200);
      chk({7'h00, BUSY}, 8'h01);
      wait_idle(30);
      setf(8'hB0, 8'h16);
   endtask
   // Data move tail, then a long status read across the end of an erase
   task automatic t_move();
      cmd(1, 32'h0600_0000);
      cmd(4, 32'h8400_0012);
      rd(8'hC0, 8'h02);
      cmd(4, 32'h8400_0034);
      cmd(4, 32'h1000_0300);
      chk({7'h00, BUSY}, 8'h01);
      wait_idle(30);
      cmd(1, 32'h0600_0000);
      cmd(4, 32'hD800_0400);
      // Output enable must stand 300 ns in, inside the answer phase, and drop after the frame
      fork
         u_host.frame(2, 32'h0FC0_0000, 12, r0, r1);
         begin
            #300;
            chk({7'h00, SO_OE}, 8'h01);
         end
      join
      chk({7'h00, SO_OE}, 8'h00);
      chk(r0, 8'h03);
      chk(r1, 8'h02);
   endtask

   // ==========================================
   // Main sequence, watchdog and verdict
   initial
   begin
      ARST_N = 1'b0;
      WP_N = 1'b1;
      ECC_STAT = 2'h3;
      BF_CNT = 4'h9;
      repeat (20) @(negedge CLK);
      ARST_N = 1'b1;
      repeat (4) @(negedge CLK);
      t_defaults();
      t_latch();
      t_guard();
      t_range();
      t_reset();
      t_prot();
      t_move();
      give_verdict();
   end
   // About four times the expected run
   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule
`default_nettype wire
